// ### hw/usart_pkg.sv
// Purpose: Shared constants, types and frame helpers for both ends of the serial link.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Frame bits after the start bit are sent least significant first.
package usart_pkg;
   localparam int AW = 8;
   localparam logic [AW-1:0] A_CFG = 8'h00;
   localparam logic [AW-1:0] A_CTL = 8'h04;
   localparam logic [AW-1:0] A_ISTAT = 8'h08;
   localparam logic [AW-1:0] A_IMASK = 8'h0c;
   localparam logic [AW-1:0] A_STAT = 8'h10;
   localparam logic [AW-1:0] A_RXDAT = 8'h14;
   localparam logic [AW-1:0] A_RXSTAT = 8'h18;
   localparam logic [AW-1:0] A_TXDAT = 8'h1c;
   localparam logic [AW-1:0] A_BRG = 8'h20;
   // Configuration word fields.
   localparam int CFG_EN = 0;
   localparam int CFG_LEN = 1;
   localparam int CFG_PAR = 3;
   localparam int CFG_STOP2 = 5;
   localparam int CFG_SYNC = 6;
   localparam int CFG_MST = 7;
   localparam int CFG_SPOL = 8;
   localparam int CFG_CONT = 9;
   localparam int CFG_CTSE = 10;
   localparam int CFG_LOOP = 11;
   localparam int CFG_FLOOP = 12;
   localparam int CFG_SCLKO = 13;
   localparam int CTL_BRK = 0;
   localparam int CTL_TXDIS = 1;
   localparam int BRG_DIV = 0;
   localparam int BRG_OSR = 16;
   // Interrupt status and mask bits.
   localparam int IRQ_RXRDY = 0;
   localparam int IRQ_TXRDY = 1;
   localparam int IRQ_RXIDLE = 2;
   localparam int IRQ_DBRK = 3;
   localparam int IRQ_FERR = 4;
   localparam int IRQ_PERR = 5;
   localparam int IRQ_OVR = 6;
   localparam int IRQ_UNR = 7;
   localparam int IRQ_DCTS = 8;
   localparam int IRQ_NOISE = 9;
   localparam int IRQ_W = 10;
   // Live status bits and per-character receive flags.
   localparam int ST_RXFULL = 0;
   localparam int ST_TXEMPTY = 1;
   localparam int ST_RXIDLE = 2;
   localparam int ST_RXBRK = 3;
   localparam int ST_CTS = 4;
   localparam int ST_TXIDLE = 5;
   localparam int RXST_FERR = 13;
   localparam int RXST_PERR = 14;
   localparam int RXST_BRK = 15;
   localparam int RXST_NOISE = 16;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [31:0] CTL_RST = 32'h0000_0000;
   localparam logic [31:0] BRG_RST = 32'h000f_0000;
   localparam logic [1:0] PAR_EVEN = 2'h2;
   localparam logic [1:0] PAR_ODD = 2'h3;
   localparam int FRAME_W = 13;

   typedef enum logic {LINE_IDLE, LINE_RUN} line_state_e;

   function automatic logic [3:0] data_bits(input logic [1:0] len);
      return (len == 2'h0) ? 4'h7 : ((len == 2'h1) ? 4'h8 : 4'h9);
   endfunction

   function automatic logic [8:0] data_mask(input logic [1:0] len);
      return (len == 2'h0) ? 9'h07f : ((len == 2'h1) ? 9'h0ff : 9'h1ff);
   endfunction

   // Returns {bit count after start, frame bits}; unused upper bits are stop level.
   function automatic logic [FRAME_W+3:0] build_frame(input logic [8:0] d, input logic [1:0] len,
                                                     input logic [1:0] par, input logic stop2);
      logic [FRAME_W-1:0] f;
      logic [8:0] dm;
      logic [3:0] nd;
      f = {FRAME_W{1'b1}};
      dm = d & data_mask(len);
      nd = data_bits(len);
      f[8:0] = dm | ~data_mask(len);
      if (par[1]) begin
         f[nd] = (^dm) ^ par[0];
      end
      return {4'(nd + {3'h0, par[1]} + 4'h1 + {3'h0, stop2}), f};
   endfunction

   function automatic logic parity_bad(input logic [8:0] d, input logic [1:0] len, input logic [1:0] par,
                                       input logic pbit);
      return par[1] & (pbit != ((^(d & data_mask(len))) ^ par[0]));
   endfunction
endpackage

// ### hw/usart_link_if.sv
// Purpose: Serial link between the transceiver and the remote end.
// Assumes: The serial clock is a shared two-way wire, high when nobody drives it.
// Notes: The device end wins if both ends drive the clock.
`timescale 1ns/10ps
interface usart_link_if;
   logic d2p_data;
   logic p2d_data;
   logic d_rts_n;
   logic p_rts_n;
   logic d_sclk_o;
   logic d_sclk_oe;
   logic p_sclk_o;
   logic p_sclk_oe;
   logic sclk;

   assign sclk = d_sclk_oe ? d_sclk_o : (p_sclk_oe ? p_sclk_o : 1'b1);

   modport dev (output d2p_data, d_rts_n, d_sclk_o, d_sclk_oe, input p2d_data, p_rts_n, sclk);
   modport par (output p2d_data, p_rts_n, p_sclk_o, p_sclk_oe, input d2p_data, d_rts_n, sclk);
endinterface

// ### hw/usart_device.sv
// Purpose: Serial transceiver with APB registers, async and sync modes, flow control and interrupts.
// Assumes: All inputs synchronous to pclk; frac_tick is a one-cycle pulse from the shared divider.
// Notes: Zero-wait APB slave; read data is captured in the setup cycle.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
// Contract
// - Seven, eight or nine data bits per frame.
// - One or two stop bits appended.
// - Odd, even or no parity generated, checked.
// - Sync master or slave, sample phase, continuous clock.
// - Ninth bit marks addresses; software compares.
// - Single transmit and single receive buffer.
// - RTS holds sender; CTS pauses transmission.
// - CTS change flagged; transmit disable control.
// - Combined read of data plus status.
// - Send break; detect break, flag changes.
// - Three-sample majority vote, noise flag.
// - Own baud generator fed by shared divider.
// - Ten maskable interrupt conditions.
// - Separate data and flow-control loopback.
// - Async baud clock optionally on serial clock.
// - Up to 1.875 / 10 Mbit/s.
module usart_device (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [usart_pkg::AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Tick from the fractional divider shared by all instances.
   input wire logic frac_tick,
   // Interrupt.
   output logic irq,
   // Serial link.
   usart_link_if.dev link
);
   import usart_pkg::*;

   logic [31:0] cfg, ctl, brg, rd_mux;
   logic [IRQ_W-1:0] istat, imask, ev;
   logic hit, wr, pop, en, sync, mst, spol, ctse, tick, run_clk, sclk_q, sclk_prev;
   logic m_samp, m_launch, s_samp, s_launch, tx_stb;
   logic [15:0] brg_cnt;
   logic [3:0] osr, mid, tx_os, rx_os, txn, rxn, last, nd;
   logic txd_int, rts_n_int, rxd, cts_n, cts_prev, go, load_ok;
   logic [8:0] txh, rxb;
   logic txh_full, rx_full;
   logic [FRAME_W-1:0] txf;
   line_state_e tx_st, rx_st;
   logic v0, v1, vote, noise, bit_stb, bit_val, bit_nz, fin, store, rx_start, nz, allz, brk_st;
   logic [10:0] rxsh;
   logic [8:0] fin_data;
   logic [3:0] rxb_flags;

   assign en = cfg[CFG_EN];
   assign sync = cfg[CFG_SYNC];
   assign mst = cfg[CFG_MST];
   assign spol = cfg[CFG_SPOL];
   assign ctse = cfg[CFG_CTSE];
   assign osr = brg[BRG_OSR+:4];
   assign mid = {1'b0, osr[3:1]};
   assign nd = data_bits(cfg[CFG_LEN+:2]);
   assign last = 4'(nd + {3'h0, cfg[CFG_PAR+1]} + 4'h1);

   // APB decode; pready is always given in the first access cycle.
   assign pready = psel & penable;
   assign wr = psel & penable & pwrite & hit;
   assign pop = psel & penable & ~pwrite & ((paddr == A_RXDAT) | (paddr == A_RXSTAT));
   assign pslverr = psel & penable & ~hit;

   always_comb begin
      hit = 1'b1;
      rd_mux = 32'h0;
      case (paddr)
         A_CFG: rd_mux = cfg;
         A_CTL: rd_mux = ctl;
         A_ISTAT: rd_mux = {22'h0, istat};
         A_IMASK: rd_mux = {22'h0, imask};
         A_STAT: rd_mux = {26'h0, tx_st == LINE_IDLE, ~cts_n, brk_st, rx_st == LINE_IDLE, ~txh_full, rx_full};
         A_RXDAT: rd_mux = {23'h0, rxb};
         A_RXSTAT: rd_mux = {15'h0, rxb_flags, 4'h0, rxb};
         A_TXDAT: rd_mux = 32'h0;
         A_BRG: rd_mux = brg;
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel & ~penable) begin
         prdata <= rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= CFG_RST;
         ctl <= CTL_RST;
         brg <= BRG_RST;
         imask <= '0;
      end else if (wr) begin
         case (paddr)
            A_CFG: cfg <= {18'h0, pwdata[13:0]};
            A_CTL: ctl <= {30'h0, pwdata[1:0]};
            A_IMASK: imask <= pwdata[IRQ_W-1:0];
            A_BRG: brg <= {12'h0, (pwdata[19:16] < 4'h4) ? 4'h4 : pwdata[19:16], pwdata[15:0]};
            default: ;
         endcase
      end
   end

   // Sticky flags; a new event wins over a write-one-to-clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat <= '0;
         irq <= 1'b0;
      end else begin
         istat <= (istat & ~((wr && paddr == A_ISTAT) ? pwdata[IRQ_W-1:0] : '0)) | ev;
         irq <= |(istat & imask);
      end
   end

   // Own baud generator; a tick every cycle gives 10 Mbit/s sync or 20 MHz / (osr + 1) async.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brg_cnt <= 16'h0;
      end else if (frac_tick) begin
         brg_cnt <= (brg_cnt >= brg[BRG_DIV+:16]) ? 16'h0 : 16'(brg_cnt + 16'h1);
      end
   end
   assign tick = frac_tick & (brg_cnt >= brg[BRG_DIV+:16]);

   // Loopbacks replace the far end inside the block.
   assign rxd = cfg[CFG_LOOP] ? txd_int : link.p2d_data;
   assign cts_n = cfg[CFG_FLOOP] ? rts_n_int : link.p_rts_n;
   assign link.d2p_data = cfg[CFG_LOOP] ? 1'b1 : txd_int;
   assign link.d_rts_n = cfg[CFG_FLOOP] ? 1'b1 : rts_n_int;
   assign link.d_sclk_o = sclk_q;
   assign link.d_sclk_oe = en & (sync ? mst : cfg[CFG_SCLKO]);

   // Serial clock: idle level is the one before the sampling edge.
   assign run_clk = en & sync & mst & ((tx_st == LINE_RUN) | cfg[CFG_CONT]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_q <= 1'b1;
         sclk_prev <= 1'b1;
         tx_os <= 4'h0;
      end else begin
         sclk_prev <= link.sclk;
         if (tick) begin
            tx_os <= (tx_os >= osr) ? 4'h0 : 4'(tx_os + 4'h1);
         end
         if (sync & ~run_clk) begin
            sclk_q <= ~spol;
         end else if (tick) begin
            sclk_q <= ~sclk_q;
         end
      end
   end
   assign m_samp = tick & run_clk & (sclk_q == ~spol);
   assign m_launch = tick & run_clk & (sclk_q == spol);
   assign s_samp = mst ? m_samp : (spol ? (link.sclk & ~sclk_prev) : (~link.sclk & sclk_prev));
   assign s_launch = mst ? m_launch : (spol ? (~link.sclk & sclk_prev) : (link.sclk & ~sclk_prev));
   assign tx_stb = sync ? s_launch : (tick & (tx_os >= osr));

   // Transmit holding buffer and shifter.
   assign load_ok = (sync & mst) ? ((sclk_q == ~spol) & ~tick) : tx_stb;
   assign go = en & (tx_st == LINE_IDLE) & txh_full & ~ctl[CTL_TXDIS] & ~ctl[CTL_BRK] & (~ctse | ~cts_n)
               & load_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txh <= 9'h0;
         txh_full <= 1'b0;
      end else if (go) begin
         txh_full <= 1'b0;
      end else if (wr && paddr == A_TXDAT && !txh_full) begin
         txh <= pwdata[8:0];
         txh_full <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st <= LINE_IDLE;
         txd_int <= 1'b1;
         txf <= '1;
         txn <= 4'h0;
      end else if (!en) begin
         tx_st <= LINE_IDLE;
         txd_int <= 1'b1;
      end else begin
         case (tx_st)
            LINE_IDLE: begin
               txd_int <= ~ctl[CTL_BRK];
               if (go) begin
                  txd_int <= 1'b0;
                  {txn, txf} <= build_frame(txh, cfg[CFG_LEN+:2], cfg[CFG_PAR+:2], cfg[CFG_STOP2]);
                  tx_st <= LINE_RUN;
               end
            end
            LINE_RUN: begin
               if (tx_stb) begin
                  if (txn == 4'h0) begin
                     tx_st <= LINE_IDLE;
                  end else begin
                     txd_int <= txf[0];
                     txf <= {1'b1, txf[FRAME_W-1:1]};
                     txn <= 4'(txn - 4'h1);
                  end
               end
            end
            default: tx_st <= LINE_IDLE;
         endcase
      end
   end

   // Receiver: async bits are voted from three samples around mid-bit.
   assign vote = (v0 & v1) | (v0 & rxd) | (v1 & rxd);
   assign noise = ~((v0 == v1) & (v1 == rxd));
   assign bit_stb = (rx_st == LINE_RUN) & (sync ? s_samp : (tick & (rx_os == 4'(mid + 4'h1))));
   assign bit_val = sync ? rxd : vote;
   assign bit_nz = ~sync & noise;
   assign fin = bit_stb & (rxn != 4'h0) & (rxn == last);
   assign rx_start = en & (rx_st == LINE_IDLE) & ~brk_st & ~rxd & (sync ? s_samp : tick);
   assign fin_data = rxsh[8:0] & data_mask(cfg[CFG_LEN+:2]);
   assign store = fin & (~rx_full | pop);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st <= LINE_IDLE;
         rx_os <= 4'h0;
         rxn <= 4'h0;
         rxsh <= 11'h0;
         v0 <= 1'b1;
         v1 <= 1'b1;
         nz <= 1'b0;
         allz <= 1'b1;
      end else if (!en) begin
         rx_st <= LINE_IDLE;
      end else if (rx_start) begin
         rx_st <= LINE_RUN;
         rx_os <= 4'h0;
         rxn <= sync ? 4'h1 : 4'h0;
         nz <= 1'b0;
         allz <= 1'b1;
      end else if (rx_st == LINE_RUN) begin
         if (tick) begin
            rx_os <= (rx_os >= osr) ? 4'h0 : 4'(rx_os + 4'h1);
            if (rx_os == 4'(mid - 4'h1)) v0 <= rxd;
            if (rx_os == mid) v1 <= rxd;
         end
         if (bit_stb) begin
            nz <= nz | bit_nz;
            allz <= allz & ~bit_val;
            if (rxn == 4'h0) begin
               if (bit_val) rx_st <= LINE_IDLE;
               rxn <= 4'h1;
            end else if (fin) begin
               rx_st <= LINE_IDLE;
            end else begin
               rxsh[4'(rxn - 4'h1)] <= bit_val;
               rxn <= 4'(rxn + 4'h1);
            end
         end
      end
   end

   // Receive buffer; a character that finds it full is dropped, the old one kept.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxb <= 9'h0;
         rxb_flags <= 4'h0;
         rx_full <= 1'b0;
      end else if (store) begin
         rxb <= fin_data;
         rxb_flags <= {nz | bit_nz, allz & ~bit_val, parity_bad(fin_data, cfg[CFG_LEN+:2], cfg[CFG_PAR+:2],
                       rxsh[nd]), ~bit_val};
         rx_full <= 1'b1;
      end else if (pop) begin
         rx_full <= 1'b0;
      end
   end

   // Break state, flow control and change detectors.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brk_st <= 1'b0;
         rts_n_int <= 1'b1;
         cts_prev <= 1'b1;
      end else begin
         cts_prev <= cts_n;
         rts_n_int <= ~en | (ctse & rx_full);
         if (fin & allz & ~bit_val) begin
            brk_st <= 1'b1;
         end else if ((rx_st == LINE_IDLE) & rxd) begin
            brk_st <= 1'b0;
         end
      end
   end

   always_comb begin
      ev = '0;
      ev[IRQ_RXRDY] = store;
      ev[IRQ_TXRDY] = go;
      ev[IRQ_RXIDLE] = fin;
      ev[IRQ_DBRK] = (fin & allz & ~bit_val & ~brk_st) | (brk_st & (rx_st == LINE_IDLE) & rxd);
      ev[IRQ_FERR] = fin & ~bit_val;
      ev[IRQ_PERR] = fin & parity_bad(fin_data, cfg[CFG_LEN+:2], cfg[CFG_PAR+:2], rxsh[nd]);
      ev[IRQ_OVR] = fin & ~store;
      ev[IRQ_UNR] = rx_start & sync & ~mst & (tx_st == LINE_IDLE) & ~txh_full;
      ev[IRQ_DCTS] = cts_n ^ cts_prev;
      ev[IRQ_NOISE] = fin & (nz | bit_nz);
   end
endmodule // usart_device

// ### hw/usart_partner.sv
// Purpose: Remote serial end: sends and receives the same frames as the transceiver.
// Assumes: bit_div counts pclk cycles per bit (async) or per half bit (sync master), at least 2.
// Notes: Samples once per bit, at mid-bit in async mode.
`timescale 1ns/10ps
module usart_partner (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Frame and link settings; must match the transceiver.
   input wire logic [1:0] len,
   input wire logic [1:0] par,
   input wire logic stop2,
   input wire logic sync_mode,
   input wire logic master,
   input wire logic spol,
   input wire logic flow_en,
   input wire logic [7:0] bit_div,
   // Transmit side.
   input wire logic [8:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic send_break,
   input wire logic hold,
   // Receive side.
   output logic [8:0] rx_data,
   output logic rx_valid,
   output logic rx_ferr,
   output logic rx_perr,
   // Serial link.
   usart_link_if.par link
);
   import usart_pkg::*;

   logic [7:0] cnt, rcnt;
   logic tick, sclk_q, sclk_prev, s_samp, s_launch, tx_stb, txd_q, go, bit_stb, fin;
   logic [FRAME_W-1:0] txf;
   logic [3:0] txn, rxn, last;
   line_state_e tx_st, rx_st;
   logic [10:0] rxsh;

   assign tick = (cnt >= 8'(bit_div - 8'h1));
   assign last = 4'(data_bits(len) + {3'h0, par[1]} + 4'h1);
   assign link.p2d_data = txd_q;
   assign link.p_sclk_o = sclk_q;
   assign link.p_sclk_oe = sync_mode & master;
   assign s_samp = spol ? (link.sclk & ~sclk_prev) : (~link.sclk & sclk_prev);
   assign s_launch = spol ? (~link.sclk & sclk_prev) : (link.sclk & ~sclk_prev);
   assign tx_stb = sync_mode ? s_launch : tick;
   assign tx_ready = (tx_st == LINE_IDLE) & ~send_break & (~flow_en | ~link.d_rts_n)
                     & (sync_mode & master ? ((sclk_q == ~spol) & ~tick) : tx_stb);
   assign go = tx_valid & tx_ready;
   assign bit_stb = (rx_st == LINE_RUN) & (sync_mode ? s_samp : (rcnt == 8'h0));
   assign fin = bit_stb & (rxn != 4'h0) & (rxn == last);

   // Bit timer and continuous clock when this end is the sync master.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 8'h0;
         sclk_q <= 1'b1;
         sclk_prev <= 1'b1;
         link.p_rts_n <= 1'b1;
      end else begin
         cnt <= tick ? 8'h0 : 8'(cnt + 8'h1);
         sclk_prev <= link.sclk;
         link.p_rts_n <= hold;
         if (!(sync_mode & master)) begin
            sclk_q <= ~spol;
         end else if (tick) begin
            sclk_q <= ~sclk_q;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st <= LINE_IDLE;
         txd_q <= 1'b1;
         txf <= '1;
         txn <= 4'h0;
      end else begin
         case (tx_st)
            LINE_IDLE: begin
               txd_q <= ~send_break;
               if (go) begin
                  txd_q <= 1'b0;
                  {txn, txf} <= build_frame(tx_data, len, par, stop2);
                  tx_st <= LINE_RUN;
               end
            end
            LINE_RUN: begin
               if (tx_stb) begin
                  if (txn == 4'h0) begin
                     tx_st <= LINE_IDLE;
                  end else begin
                     txd_q <= txf[0];
                     txf <= {1'b1, txf[FRAME_W-1:1]};
                     txn <= 4'(txn - 4'h1);
                  end
               end
            end
            default: tx_st <= LINE_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st <= LINE_IDLE;
         rcnt <= 8'h0;
         rxn <= 4'h0;
         rxsh <= 11'h0;
      end else begin
         case (rx_st)
            LINE_IDLE: begin
               if (!link.d2p_data && (!sync_mode || s_samp)) begin
                  rx_st <= LINE_RUN;
                  rcnt <= {1'b0, bit_div[7:1]};
                  rxn <= sync_mode ? 4'h1 : 4'h0;
               end
            end
            LINE_RUN: begin
               rcnt <= (rcnt == 8'h0) ? 8'(bit_div - 8'h1) : 8'(rcnt - 8'h1);
               if (bit_stb) begin
                  if (rxn == 4'h0) begin
                     if (link.d2p_data) rx_st <= LINE_IDLE;
                     rxn <= 4'h1;
                  end else if (fin) begin
                     rx_st <= LINE_IDLE;
                  end else begin
                     rxsh[4'(rxn - 4'h1)] <= link.d2p_data;
                     rxn <= 4'(rxn + 4'h1);
                  end
               end
            end
            default: rx_st <= LINE_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_data <= 9'h0;
         rx_valid <= 1'b0;
         rx_ferr <= 1'b0;
         rx_perr <= 1'b0;
      end else begin
         rx_valid <= fin;
         if (fin) begin
            rx_data <= rxsh[8:0] & data_mask(len);
            rx_ferr <= ~link.d2p_data;
            rx_perr <= parity_bad(rxsh[8:0], len, par, rxsh[data_bits(len)]);
         end
      end
   end
endmodule // usart_partner

// ### test/usart_link_props.sv
// Purpose: Link checks between the transceiver and the remote end.
// Assumes: Async mode, sixteen cycles per bit on both ends.
// Notes: The remote end honours RTS.
`timescale 1ns/10ps
module usart_link_props (
   // Clock and reset.
   input logic pclk,
   input logic presetn,
   // Link.
   input logic d2p_data,
   input logic p2d_data,
   input logic d_rts_n,
   input logic p_rts_n,
   input logic d_sclk_oe,
   input logic p_sclk_oe,
   input logic sclk
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rst; !$past(presetn) |-> d2p_data && d_rts_n && p2d_data && p_rts_n && !d_sclk_oe; endproperty
   a_rst: assert property (p_rst) else $error("link busy after reset");
   property p_db; $changed(d2p_data) |=> $stable(d2p_data) [*8]; endproperty
   a_db: assert property (p_db) else $error("short bit sent");
   property p_pb; $changed(p2d_data) |=> $stable(p2d_data) [*8]; endproperty
   a_pb: assert property (p_pb) else $error("short bit received");
   property p_ds; $fell(d2p_data) |-> !d2p_data [*8]; endproperty
   a_ds: assert property (p_ds) else $error("short start bit");
   property p_dstop; $fell(d2p_data) |-> $past(d2p_data, 8); endproperty
   a_dstop: assert property (p_dstop) else $error("start without stop");
   property p_ps; $fell(p2d_data) |=> !p2d_data [*7]; endproperty
   a_ps: assert property (p_ps) else $error("short remote start");
   property p_rts; d_rts_n [*3] |=> !$fell(p2d_data); endproperty
   a_rts: assert property (p_rts) else $error("start against rts");
   property p_clk; !(d_sclk_oe && p_sclk_oe); endproperty
   a_clk: assert property (p_clk) else $error("both ends drive the clock");
endmodule // usart_link_props

// ### test/test_usart_async_sync_serial.sv
// Purpose: Self-checking bench for the transceiver and the remote end.
// Assumes: Async mode, divider tick every cycle, sixteen cycles per bit.
// Notes: Frame formats, overrun, break and interrupts.
`timescale 1ns/10ps
module test_usart_async_sync_serial;
   import usart_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
   logic [7:0] paddr = 8'h00, bit_div = 8'h10;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [1:0] len = 2'h0, par = 2'h0;
   logic stop2 = 1'b0, tx_valid = 1'b0, send_break = 1'b0, hold = 1'b0, tx_ready, rx_valid, rx_ferr, rx_perr;
   logic [8:0] tx_data = 9'h000, rx_data;
   int n_mismatch = 0, tests_run = 0;
   always #25 pclk = ~pclk;
   usart_link_if link ();
   usart_device i_usart_device (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .frac_tick(1'b1), .irq, .link(link.dev));
   usart_partner i_usart_partner (.pclk, .presetn, .len, .par, .stop2, .sync_mode(1'b0), .master(1'b0),
      .spol(1'b0), .flow_en(1'b1), .bit_div, .tx_data, .tx_valid, .tx_ready, .send_break, .hold, .rx_data,
      .rx_valid, .rx_ferr, .rx_perr, .link(link.par));
   usart_link_props i_props (.pclk, .presetn, .d2p_data(link.d2p_data), .p2d_data(link.p2d_data),
      .d_rts_n(link.d_rts_n), .p_rts_n(link.p_rts_n), .d_sclk_oe(link.d_sclk_oe), .p_sclk_oe(link.p_sclk_oe),
      .sclk(link.sclk));
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask
   task automatic wait_for(input int sel, input string what);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while ((sel == 0 ? pready : sel == 1 ? irq : sel == 2 ? tx_ready : rx_valid) !== 1'b1 && n < 600);
      if (n >= 600) begin
         chk(what, 32'h1, 32'h0);
         final_report();
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
      @(posedge pclk);
      penable <= 1'b1;
      wait_for(0, "pready");
      r = prdata;
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask
   task automatic p_send(input logic [8:0] d);
      {tx_data, tx_valid} <= {d, 1'b1};
      wait_for(2, "tx_ready");
      tx_valid <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic t_frames();
      logic [31:0] cfg;
      logic [8:0] m;
      apb(1'b1, A_IMASK, 32'h1 << IRQ_RXRDY);
      for (int k = 0; k < 3; k++) begin
         m = 9'h1ff >> (2 - k);
         cfg = 32'h1 | 32'(k << CFG_LEN) | 32'((k == 2 ? 0 : k + 2) << CFG_PAR)
               | ((k == 1 ? 32'h1 : 32'h0) << CFG_STOP2);
         {len, par, stop2} <= {cfg[CFG_LEN +: 2], cfg[CFG_PAR +: 2], cfg[CFG_STOP2]};
         apb(1'b1, A_CFG, cfg);
         apb(1'b1, A_TXDAT, 32'h1a5);
         wait_for(3, "rx_valid");
         chk("remote data", 32'(9'h1a5 & m), 32'(rx_data & m));
         chk("remote errors", 32'h0, {30'h0, rx_ferr, rx_perr});
         p_send(9'h15a);
         wait_for(1, "irq");
         apb(1'b0, A_RXSTAT, 32'h0);
         chk("rxstat", 32'(9'h15a & m), r);
         apb(1'b1, A_ISTAT, 32'h3ff);
      end
      $display("t_frames done");
   endtask
   task automatic t_overrun();
      apb(1'b1, A_IMASK, 32'h1 << IRQ_OVR);
      p_send(9'h011);
      p_send(9'h022);
      wait_for(1, "irq");
      apb(1'b0, A_RXDAT, 32'h0);
      chk("kept char", 32'h11, r);
      apb(1'b1, A_IMASK, 32'h0);
      @(posedge pclk);
      chk("irq masked", 32'h0, 32'(irq));
      apb(1'b1, A_ISTAT, 32'h1 << IRQ_OVR);
      apb(1'b0, A_ISTAT, 32'h0);
      chk("overrun flag", 32'h0, 32'(r[IRQ_OVR]));
      $display("t_overrun done");
   endtask
   task automatic t_flow();
      apb(1'b1, A_CFG, 32'h1 | 32'(2 << CFG_LEN) | (32'h1 << CFG_CTSE));
      hold <= 1'b1;
      apb(1'b1, A_TXDAT, 32'h0c3);
      repeat (40) @(posedge pclk);
      apb(1'b0, A_STAT, 32'h0);
      chk("tx held by cts", 32'h0, 32'(r[ST_TXEMPTY]));
      hold <= 1'b0;
      wait_for(3, "rx_valid");
      chk("remote data after cts", 32'h0c3, 32'(rx_data));
      $display("t_flow done");
   endtask
   task automatic t_break();
      apb(1'b1, A_ISTAT, 32'h3ff);
      apb(1'b1, A_IMASK, 32'h1 << IRQ_DBRK);
      {send_break, hold} <= 2'b11;
      wait_for(1, "irq");
      apb(1'b0, A_STAT, 32'h0);
      chk("break state", 32'h1, 32'(r[ST_RXBRK]));
      {send_break, hold} <= 2'b00;
      $display("t_break done");
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_frames();
      t_overrun();
      t_flow();
      t_break();
      final_report();
   end
endmodule // test_usart_async_sync_serial
